/* rtl/group_stop_defs.svh */
// Constants for the group stop interlock: timing counts and encodings.
// Assumes a 50 MHz core clock; included by the package and the design.
`ifndef GROUP_STOP_DEFS_SVH
`define GROUP_STOP_DEFS_SVH

`define CLK_PERIOD_NS 20
// Indicator flash half-period in ms, and derived cycle count
`define FLASH_HALF_MS 250
`define FLASH_HALF_CYC ((`FLASH_HALF_MS * 1000000) / `CLK_PERIOD_NS)
`define FLASH_CNT_W 24
// Group status encodings reported to the supervisory controller
`define GSTAT_STARTED 2'h0
`define GSTAT_STOP_ACTIVE 2'h1
`define GSTAT_AWAIT_START 2'h2
// Output register command bits
`define CMD_STOP_BIT 0
`define CMD_START_BIT 1
// Communication-loss setting: 0 forces outputs off, 1 holds last state
`define COMLOSS_OFF 1'h0
`define COMLOSS_HOLD 1'h1

`endif

/* rtl/group_stop_pkg.sv */
// Types for the group stop interlock.
// Assumes group_stop_defs.svh is on the include path.
`include "group_stop_defs.svh"

package group_stop_pkg;

	// Stop causes collected from the module and the network side
	typedef struct packed {
		logic [1:0] btn_left_n;  // Left port contact pair, low = open
		logic [1:0] btn_right_n; // Right port contact pair, low = open
		logic peer_stop;         // Stop received from either ring
		logic member_missing;    // A configured member is absent
		logic member_unpowered;  // A member lost power
		logic ctrl_conn_lost;    // Established controller link dropped
	} stop_cause_type;

	// Indicator drive: motor, sensor, control red LEDs plus the others
	typedef struct packed {
		logic motor_red;
		logic sensor_red;
		logic control_red;
		logic link;
		logic network;
		logic status;
	} led_type;

	typedef enum logic [1:0] {
		ST_STARTED = 2'b00,
		ST_STOP_ACTIVE = 2'b01,
		ST_AWAIT_START = 2'b10
	} group_state_type;

endpackage : group_stop_pkg

/* rtl/group_stop_interlock.sv */
// Group stop interlock for one conveyor motor controller module.
// Assumes synchronous inputs on core_clk_i, configuration held stable.
//
// Functional notes
// - Any open contact of an assigned button raises stop on both rings.
// - Controller stop to any one member stops the whole group.
// - A missing configured member stops the whole group.
// - Loss of an established controller connection stops the group.
// - Power loss of any member is treated as stop by others.
// - During stop the non-I/O variant flashes motor, sensor, control red; others unchanged.
// - Control port output of the assigned button toggles during stop.
// - I/O variant flashes module and network status red during stop.
// - One status input register and one command output register exist.
// - Each connected member reports status and takes commands alone.
// - Stop inhibits motor rotation on both ports in every mode.
// - During stop in controller I/O mode non-button outputs go off or hold per setting.
// - State distinguishes stop active, awaiting start, and started.
`timescale 1ns/1ns
`include "group_stop_defs.svh"

module group_stop_interlock
(
	input wire logic core_clk_i, // 50 MHz core clock
	input wire logic rst_b_i, // Synchronous reset, active low
	input wire group_stop_pkg::stop_cause_type cause_i, // Stop causes
	input wire logic btn_left_en_i, // Stop button assigned to left port
	input wire logic btn_right_en_i, // Stop button assigned to right port
	input wire logic start_btn_i, // Local start push-button, high = press
	input wire logic io_variant_i, // Module is the network I/O variant
	input wire logic ctrl_io_mode_i, // Module in controller_io_mode
	input wire logic zone_accumulation_mode_i, // Module in accumulation mode
	input wire logic comloss_hold_i, // Comm-loss setting, 1 = hold
	input wire logic ctrl_conn_up_i, // Controller instance link is up
	input wire logic [1:0] ctrl_cmd_i, // Controller command register
	input wire logic ctrl_cmd_wr_i, // Command register write strobe
	input wire logic peer_start_i, // Start received from either ring
	input wire logic [1:0] motor_run_req_i, // Motor run from mode logic
	input wire logic [1:0] dout_req_i, // Control port outputs from mode
	input wire group_stop_pkg::led_type led_req_i, // Normal LED drive
	input wire logic [1:0] netio_led_req_i, // I/O variant mod/net red
	output group_stop_pkg::group_state_type state_o, // Group state
	output logic [1:0] ctrl_status_o, // Controller status register
	output logic ring_stop_o, // Stop message to both rings
	output logic ring_start_o, // Start message to both rings
	output logic [1:0] motor_run_o, // Gated motor run per port
	output logic [1:0] dout_o, // Control port outputs, left/right
	output group_stop_pkg::led_type led_o, // LED drive
	output logic [1:0] netio_led_o // I/O variant mod/net red LEDs
);
	import group_stop_pkg::*;

	group_state_type state_reg;
	group_state_type state_next;
	logic [`FLASH_CNT_W-1:0] flash_cnt_reg;
	logic flash_reg;
	logic [1:0] dout_hold_reg;
	logic conn_seen_reg;
	logic ctrl_stop_reg;
	logic cause_present;
	logic local_btn_stop;
	logic start_cmd;
	logic stopped;

	// True when either contact of an enabled button is open
	function automatic logic btn_open(input logic en, input logic [1:0] c_n);
		btn_open = en & ~(&c_n);
	endfunction : btn_open

	// Both contacts are read so a single welded contact still trips
	assign local_btn_stop = btn_open(btn_left_en_i, cause_i.btn_left_n) |
		btn_open(btn_right_en_i, cause_i.btn_right_n);

	// Controller link: remember it was established so a drop is a cause
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
			conn_seen_reg <= 1'b0;
		else if (ctrl_conn_up_i)
			conn_seen_reg <= 1'b1;
		else if (start_cmd && state_reg == ST_AWAIT_START)
			conn_seen_reg <= 1'b0; // Lost link acknowledged by start
	end

	// Controller stop is latched until a controller start; commands need a link
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
			ctrl_stop_reg <= 1'b0;
		else if (ctrl_cmd_wr_i && ctrl_conn_up_i &&
			ctrl_cmd_i[`CMD_STOP_BIT])
			ctrl_stop_reg <= 1'b1;
		else if (ctrl_cmd_wr_i && ctrl_conn_up_i &&
			ctrl_cmd_i[`CMD_START_BIT])
			ctrl_stop_reg <= 1'b0;
	end

	// Every cause that keeps the group stopped
	assign cause_present = local_btn_stop | ctrl_stop_reg |
		cause_i.peer_stop |
		cause_i.member_missing |
		(conn_seen_reg & ~ctrl_conn_up_i) | cause_i.ctrl_conn_lost |
		cause_i.member_unpowered;

	// Start from local button, peer ring, or the controller register
	assign start_cmd = start_btn_i | peer_start_i |
		(ctrl_cmd_wr_i & ctrl_conn_up_i & ctrl_cmd_i[`CMD_START_BIT] &
		~ctrl_cmd_i[`CMD_STOP_BIT]);

	// Group state; a start seen while a cause persists is ignored
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			ST_STARTED:
				if (cause_present)
					state_next = ST_STOP_ACTIVE;
			ST_STOP_ACTIVE:
				if (!cause_present)
					state_next = ST_AWAIT_START;
			ST_AWAIT_START:
				if (cause_present)
					state_next = ST_STOP_ACTIVE;
				else if (start_cmd)
					state_next = ST_STARTED;
			default:
				state_next = ST_STOP_ACTIVE;
		endcase
	end

	// Reset enters stop-active so power-up never starts motors unasked
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
			state_reg <= ST_STOP_ACTIVE;
		else
			state_reg <= state_next;
	end

	assign stopped = (state_reg != ST_STARTED);

	// Flash timer runs only while stopped, so the first phase is full
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i || !stopped)
		begin
			flash_cnt_reg <= '0;
			flash_reg <= 1'b0;
		end
		else if (flash_cnt_reg == `FLASH_CNT_W'(`FLASH_HALF_CYC - 1))
		begin
			flash_cnt_reg <= '0;
			flash_reg <= ~flash_reg;
		end
		else
			flash_cnt_reg <= flash_cnt_reg + `FLASH_CNT_W'(1);
	end

	// Last output values captured while running, for hold behaviour
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
			dout_hold_reg <= 2'h0;
		else if (!stopped)
			dout_hold_reg <= dout_req_i;
	end

	// Registered outputs toward motors, rings and controller
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			state_o <= ST_STOP_ACTIVE;
			ctrl_status_o <= `GSTAT_STOP_ACTIVE;
			ring_stop_o <= 1'b0;
			ring_start_o <= 1'b0;
			motor_run_o <= 2'h0;
		end
		else
		begin
			state_o <= state_next;
			case (state_next)
				ST_STARTED: ctrl_status_o <= `GSTAT_STARTED;
				ST_AWAIT_START: ctrl_status_o <= `GSTAT_AWAIT_START;
				default: ctrl_status_o <= `GSTAT_STOP_ACTIVE;
			endcase
			// Broadcast every own cause, not echoes from the rings
			ring_stop_o <= local_btn_stop | ctrl_stop_reg |
				cause_i.member_missing | cause_i.ctrl_conn_lost |
				(conn_seen_reg & ~ctrl_conn_up_i) |
				cause_i.member_unpowered;
			ring_start_o <= start_btn_i | (ctrl_cmd_wr_i & ctrl_conn_up_i &
				ctrl_cmd_i[`CMD_START_BIT]);
			// Mode is irrelevant: stop blocks accumulation and I/O modes
			motor_run_o <= (state_next == ST_STARTED) ?
				motor_run_req_i : 2'h0;
		end
	end

	// Control outputs: button ports toggle, others follow the mode
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
			dout_o <= 2'h0;
		else if (!stopped)
			dout_o <= dout_req_i;
		else
		begin
			if (btn_left_en_i)
				dout_o[0] <= flash_reg;
			else if (ctrl_io_mode_i && comloss_hold_i == `COMLOSS_HOLD)
				dout_o[0] <= dout_hold_reg[0];
			else if (ctrl_io_mode_i)
				dout_o[0] <= 1'b0;
			else
				dout_o[0] <= zone_accumulation_mode_i ? 1'b0 : dout_req_i[0];
			if (btn_right_en_i)
				dout_o[1] <= flash_reg;
			else if (ctrl_io_mode_i && comloss_hold_i == `COMLOSS_HOLD)
				dout_o[1] <= dout_hold_reg[1];
			else if (ctrl_io_mode_i)
				dout_o[1] <= 1'b0;
			else
				dout_o[1] <= zone_accumulation_mode_i ? 1'b0 : dout_req_i[1];
		end
	end

	// Indicators; link, network and status pass untouched
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_b_i)
		begin
			led_o <= '0;
			netio_led_o <= 2'h0;
		end
		else if (stopped && !io_variant_i)
		begin
			led_o <= led_req_i;
			led_o.motor_red <= flash_reg;
			led_o.sensor_red <= flash_reg;
			led_o.control_red <= flash_reg;
			netio_led_o <= netio_led_req_i;
		end
		else if (stopped)
		begin
			led_o <= led_req_i;
			netio_led_o <= {flash_reg, flash_reg};
		end
		else
		begin
			led_o <= led_req_i;
			netio_led_o <= netio_led_req_i;
		end
	end

endmodule : group_stop_interlock

/* sim/group_stop_checker.sv */
// Checker for the group stop interlock: state, gating and ring stop.
// Assumes it is bound to group_stop_interlock and sees its ports only.
`timescale 1ns/1ns
module group_stop_checker
(
	input wire logic core_clk_i, // Core clock
	input wire logic rst_b_i, // Sync reset, active low
	input wire group_stop_pkg::stop_cause_type cause_i, // Causes
	input wire logic btn_left_en_i, // Left button assigned
	input wire logic btn_right_en_i, // Right button assigned
	input wire logic ctrl_conn_up_i, // Controller link up
	input wire logic [1:0] ctrl_cmd_i, // Command bits
	input wire logic ctrl_cmd_wr_i, // Command strobe
	input wire group_stop_pkg::group_state_type state_o, // State
	input wire logic [1:0] ctrl_status_o, // Status register
	input wire logic ring_stop_o, // Ring stop
	input wire logic [1:0] motor_run_o // Gated motor run
);
	import group_stop_pkg::*;
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_b_i);
	// One open contact of an assigned button is enough to trip
	sequence s_trip;
		(btn_left_en_i && cause_i.btn_left_n != 2'h3) ||
		(btn_right_en_i && cause_i.btn_right_n != 2'h3);
	endsequence
	sequence s_ctrl_stop;
		ctrl_cmd_wr_i && ctrl_conn_up_i && ctrl_cmd_i[0];
	endsequence
	a_trip_ring: assert property (s_trip |=> ring_stop_o)
		else $error("button trip without ring stop");
	a_trip_state: assert property (
		s_trip |=> state_o == ST_STOP_ACTIVE)
		else $error("button trip without stop state");
	// The command is latched first, so the state follows one edge later
	a_ctrl_stop: assert property (
		s_ctrl_stop |=> ##1 state_o == ST_STOP_ACTIVE)
		else $error("controller stop ignored");
	a_missing_stop: assert property (
		cause_i.member_missing |=> state_o == ST_STOP_ACTIVE)
		else $error("missing member did not stop");
	a_link_stop: assert property (
		cause_i.ctrl_conn_lost |=> state_o == ST_STOP_ACTIVE)
		else $error("lost link did not stop");
	a_power_stop: assert property (
		cause_i.member_unpowered |=> state_o == ST_STOP_ACTIVE)
		else $error("power loss did not stop");
	a_motor_inhibit: assert property (
		state_o != ST_STARTED |-> motor_run_o == 2'h0)
		else $error("motor runs while stopped");
	a_status_mirror: assert property (ctrl_status_o == state_o)
		else $error("status differs from state");
	a_no_skip: assert property (state_o == ST_STOP_ACTIVE |=> state_o != ST_STARTED)
		else $error("left stop without await");
endmodule : group_stop_checker

bind group_stop_interlock group_stop_checker u_chk
(
	.core_clk_i,
	.rst_b_i,
	.cause_i,
	.btn_left_en_i,
	.btn_right_en_i,
	.ctrl_conn_up_i,
	.ctrl_cmd_i,
	.ctrl_cmd_wr_i,
	.state_o,
	.ctrl_status_o,
	.ring_stop_o,
	.motor_run_o
);

/* sim/group_peer_model.sv */
// Far side model: button contacts, peer causes and the controller.
// Assumes the bench calls its tasks at the falling clock edge.
`timescale 1ns/1ns
module group_peer_model
(
	input wire logic core_clk_i, // Core clock
	output group_stop_pkg::stop_cause_type cause_o, // Stop causes
	output logic [1:0] cmd_o, // Controller command bits
	output logic cmd_wr_o // Command write strobe
);
	import group_stop_pkg::*;
	// Idle: both contact sets closed, no network cause
	task clear;
		cause_o = '{2'h3, 2'h3, 1'h0, 1'h0, 1'h0, 1'h0};
	endtask : clear
	initial
	begin
		clear;
		cmd_o = 2'h0;
		cmd_wr_o = 1'h0;
	end
	// Opens one contact of a pair, or raises one network cause
	task raise(input int k);
		case (k)
			0: cause_o.btn_left_n[$urandom % 2] = 1'h0;
			1: cause_o.btn_right_n[$urandom % 2] = 1'h0;
			2: cause_o.member_missing = 1'h1;
			3: cause_o.member_unpowered = 1'h1;
			4: cause_o.ctrl_conn_lost = 1'h1;
			default: cause_o.peer_stop = 1'h1;
		endcase
	endtask : raise
	// One-cycle strobe; bits flip after so stale data never looks valid
	task write_cmd(input logic [1:0] c);
		@(negedge core_clk_i);
		cmd_o = c;
		cmd_wr_o = 1'h1;
		@(negedge core_clk_i);
		cmd_wr_o = 1'h0;
		cmd_o = ~c;
	endtask : write_cmd
endmodule : group_peer_model

/* sim/testbench.sv */
// Self-checking bench for the group stop interlock.
// Assumes the checker is bound to the design in its own file.
`timescale 1ns/1ns
module testbench;
	import group_stop_pkg::*;
	logic core_clk_i, rst_b_i, start, io_var, cio, zam, hold, conn;
	logic [1:0] run, dout, netio, status, motor, dout_o, netio_o;
	logic ring_stop, ring_start, cmd_wr, ben_l, ben_r;
	logic [1:0] cmd;
	stop_cause_type cause;
	led_type led_req, led;
	group_state_type st;
	int err_total, n_checks, k;
	initial
	begin
		core_clk_i = 1'h0;
		forever #10 core_clk_i = ~core_clk_i;
	end
	group_peer_model u_peer (.core_clk_i(core_clk_i), .cause_o(cause),
		.cmd_o(cmd), .cmd_wr_o(cmd_wr));
	// Ring start input is tied; button assignment is drawn per pass
	group_stop_interlock u_dut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
		.cause_i(cause), .btn_left_en_i(ben_l), .btn_right_en_i(ben_r),
		.start_btn_i(start), .io_variant_i(io_var), .ctrl_io_mode_i(cio),
		.zone_accumulation_mode_i(zam), .comloss_hold_i(hold),
		.ctrl_conn_up_i(conn), .ctrl_cmd_i(cmd), .ctrl_cmd_wr_i(cmd_wr),
		.peer_start_i(1'h0), .motor_run_req_i(run), .dout_req_i(dout),
		.led_req_i(led_req), .netio_led_req_i(netio), .state_o(st),
		.ctrl_status_o(status), .ring_stop_o(ring_stop),
		.ring_start_o(ring_start),
		.motor_run_o(motor), .dout_o(dout_o), .led_o(led),
		.netio_led_o(netio_o));
	function automatic logic [7:0] exp_run(input group_state_type s);
		return (s == ST_STARTED) ? 8'(run) : 8'h00;
	endfunction : exp_run
	// Stopped outputs: button ports flash (low first), others per mode
	function automatic logic [1:0] exp_dout(input logic [1:0] en);
		exp_dout = 2'h0;
		for (int i = 0; i < 2; i++)
			if (!en[i] && (cio ? hold : !zam))
				exp_dout[i] = dout[i];
	endfunction : exp_dout
	task chk(input string name, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("mismatch %s expected %h seen %h", name, e, g);
		end
	endtask : chk
	task cyc(input int n);
		repeat (n) @(negedge core_clk_i);
	endtask : cyc
	task do_start;
		start = 1'h1;
		cyc(1);
		chk("ring start", 8'h01, 8'(ring_start));
		start = 1'h0;
		cyc(1);
	endtask : do_start
	task end_sim;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_sim
	// Run is about 384 cycles; the 5000-cycle limit leaves a wide margin
	initial
	begin
		#100000;
		err_total++;
		end_sim;
	end
	initial
	begin
		{rst_b_i, start, io_var, cio, zam, hold, conn} = 7'h00;
		{ben_l, ben_r} = 2'h3;
		{run, dout, netio, led_req} = 12'h000;
		err_total = 0;
		n_checks = 0;
		k = $urandom(97);
		cyc(4);
		rst_b_i = 1'h1;
		cyc(2);
		chk("reset state", 8'(ST_AWAIT_START), 8'(st));
		u_peer.write_cmd(2'h1);
		do_start;
		chk("refused stop", 8'(ST_STARTED), 8'(st));
		conn = 1'h1;
		u_peer.write_cmd(2'h1);
		cyc(2);
		chk("ctrl stop", 8'(ST_STOP_ACTIVE), 8'(st));
		chk("status", 8'(ST_STOP_ACTIVE), 8'(status));
		rst_b_i = 1'h0;
		cyc(4);
		rst_b_i = 1'h1;
		cyc(2);
		do_start;
		// Random cause kinds and mode settings, each fully recovered
		for (int i = 0; i < 40; i++)
		begin
			k = $urandom % 6;
			ben_l = (k == 0) | 1'($urandom);
			ben_r = (k == 1) | 1'($urandom);
			run = 2'($urandom);
			dout = 2'($urandom);
			netio = 2'($urandom);
			led_req = 6'($urandom);
			{cio, zam, hold, io_var} = 4'($urandom);
			cyc(2);
			chk("run", exp_run(ST_STARTED), 8'(motor));
			u_peer.raise(k);
			cyc(1);
			chk("stop", 8'(ST_STOP_ACTIVE), 8'(st));
			chk("run", exp_run(ST_STOP_ACTIVE), 8'(motor));
			chk("ring stop", 8'(k < 5), 8'(ring_stop));
			do_start;
			chk("leds", 8'(led_req[2:0]), 8'(led[2:0]));
			chk("red leds", 8'(io_var ? led_req[5:3] : 3'h0), 8'(led[5:3]));
			chk("netio leds", 8'(io_var ? 2'h0 : netio), 8'(netio_o));
			chk("dout", 8'(exp_dout({ben_r, ben_l})), 8'(dout_o));
			u_peer.clear;
			cyc(2);
			chk("await", 8'(ST_AWAIT_START), 8'(st));
			do_start;
			chk("started", 8'(ST_STARTED), 8'(st));
		end
		conn = 1'h0;
		cyc(2);
		chk("link drop", 8'(ST_STOP_ACTIVE), 8'(st));
		end_sim;
	end
endmodule : testbench
